// ---- rtl/cfgld_pkg.sv ----
// Shared constants and types of the configuration loader.
package cfgld_pkg;
   typedef enum logic [2:0] {
      CFGLD_M_MSER = 3'b000,
      CFGLD_M_RSV1 = 3'b001,
      CFGLD_M_RSV0 = 3'b010,
      CFGLD_M_PSYN = 3'b011,
      CFGLD_M_MPUP = 3'b100,
      CFGLD_M_PASY = 3'b101,
      CFGLD_M_MPDN = 3'b110,
      CFGLD_M_SSER = 3'b111
   } cfgld_mode_e;
   localparam logic [7:0]  FILL_BYTE     = 8'hFF;
   localparam logic [3:0]  PREAMBLE      = 4'h2;
   localparam logic [3:0]  FILL_BITS     = 4'hF;
   localparam logic [3:0]  CHECK_CONST   = 4'h6;
   localparam logic [7:0]  POSTAMBLE     = 8'h7F;
   localparam int          LEN_W         = 24;
   localparam logic [4:0]  LEN_BITS      = 5'h18;
   localparam logic [2:0]  FILL_N        = 3'h4;
   localparam logic [2:0]  CHK_N         = 3'h4;
   localparam logic [3:0]  POST_N        = 4'h8;
   localparam logic [2:0]  IO_REL_CLKS   = 3'h2;
   localparam logic [2:0]  STARTUP_CLKS  = 3'h4;
   localparam int          CORE_HZ       = 20_000_000;
   localparam int          SLOW_HZ       = 1_000_000;
   localparam int          FAST_HZ       = 8_000_000;
   localparam int          SLOW_HALF     = CORE_HZ / (2 * SLOW_HZ);
   localparam int          FAST_HALF     = CORE_HZ / (2 * FAST_HZ);
   localparam int          CORE_PERIOD_NS = 50;
   localparam int          LINK_PERIOD_NS = 400;
   localparam int          HOST_HALF     = LINK_PERIOD_NS / (2 * CORE_PERIOD_NS);
   localparam logic [2:0]  WR_CYCLES     = 3'h4;
   localparam logic [2:0]  WR_RECOVER    = 3'h6;
endpackage

// ---- rtl/cfgld_if.sv ----
// Configuration link between the loading device and its source.
interface cfgld_if;
   logic       dev_clk_o;
   logic       dev_clk_oe;
   logic       host_clk_o;
   logic       host_clk_oe;
   logic       config_clock;
   logic       din;
   logic       dout;
   logic [2:0] mode_select_pins;
   logic [7:0] data;
   logic       wr_n;
   logic       rdy_busy;
   logic       init_n_o;
   logic       init_n_oe;
   logic       init_n;

   assign config_clock = dev_clk_oe ? dev_clk_o : (host_clk_oe ? host_clk_o : 1'b1);
   assign init_n = init_n_oe ? init_n_o : 1'b1;

   modport dev (
      input  config_clock, din, mode_select_pins, data, wr_n, init_n,
      output dev_clk_o, dev_clk_oe, dout, rdy_busy, init_n_o, init_n_oe
   );
   modport host (
      input  config_clock, dout, rdy_busy, init_n,
      output host_clk_o, host_clk_oe, din, mode_select_pins, data, wr_n
   );
endinterface

// ---- rtl/cfgld_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides.
module cfgld_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_data,
   input  wire logic         i_valid,
   output logic              o_ready,
   output logic [W-1:0]      o_data,
   output logic              o_valid,
   input  wire logic         i_ready
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0]   cnt_r;
   logic          push;
   logic          pop;

   assign o_ready = cnt_r != (AW+1)'(D);
   assign o_valid = cnt_r != '0;
   assign o_data  = mem[rp_r];
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;

   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem[wp_r] <= i_data;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // cfgld_fifo

// ---- rtl/cfgld_device.sv ----
// Loading device end: mode sampling, bitstream parsing, chain pass-through and start-up.
module cfgld_device #(
   parameter int FRAME_BITS = 16,
   parameter int FRAMES     = 4,
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic i_core_clk,
   input  wire logic i_rst,
   cfgld_if.dev      link,
   output logic      o_done,
   output logic      o_io_release,
   output logic      o_finished,
   output logic      o_error,
   output logic      o_fast_clk
);
   typedef enum logic [3:0] {
      CFGLD_S_HDR   = 4'h0,
      CFGLD_S_LEN   = 4'h1,
      CFGLD_S_FILL  = 4'h2,
      CFGLD_S_START = 4'h3,
      CFGLD_S_DATA  = 4'h4,
      CFGLD_S_CHK   = 4'h5,
      CFGLD_S_POST  = 4'h6,
      CFGLD_S_PASS  = 4'h7,
      CFGLD_S_ERR   = 4'h8
   } cfgld_state_e;

   cfgld_state_e              st_r;
   cfgld_pkg::cfgld_mode_e    mode_r;
   logic [1:0]                clk_s_r;
   logic                      clk_d_r;
   logic [1:0]                din_s_r;
   logic [1:0]                wr_s_r;
   logic                      wr_d_r;
   logic [7:0]                dat_s1_r;
   logic [7:0]                dat_s2_r;
   logic [2:0]                mode_s1_r;
   logic [2:0]                mode_s2_r;
   logic                      mode_ok_r;
   logic [1:0]                mode_wait_r;
   logic                      ext_clk;
   logic                      byte_mode;
   logic                      rise;
   logic                      fall;
   logic                      bit_in;
   logic                      samp_r;
   logic                      dout_r;
   logic                      pass_r;
   logic [7:0]                sh_r;
   logic [15:0]               bcnt_r;
   logic [15:0]               fcnt_r;
   logic [cfgld_pkg::LEN_W-1:0] len_r;
   logic [cfgld_pkg::LEN_W-1:0] ccnt_r;
   logic                      len_ok_r;
   logic                      match_r;
   logic [2:0]                post_r;
   logic                      fast_r;
   logic                      gen_clk_r;
   logic [3:0]                div_r;
   logic                      run;
   logic                      tick;
   logic [7:0]                sr_r;
   logic [3:0]                bits_r;
   logic [7:0]                f_data;
   logic                      f_valid;
   logic                      f_pop;
   logic                      f_ready;
   logic                      wr_fall;

   // Input synchronisers for everything arriving from the link.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         clk_s_r   <= 2'h3;
         din_s_r   <= 2'h3;
         wr_s_r    <= 2'h3;
         dat_s1_r  <= 8'hFF;
         dat_s2_r  <= 8'hFF;
         mode_s1_r <= 3'h7;
         mode_s2_r <= 3'h7;
         clk_d_r   <= 1'b1;
         wr_d_r    <= 1'b1;
      end else begin
         clk_s_r   <= {clk_s_r[0], link.config_clock};
         din_s_r   <= {din_s_r[0], link.din};
         wr_s_r    <= {wr_s_r[0], link.wr_n};
         dat_s1_r  <= link.data;
         dat_s2_r  <= dat_s1_r;
         mode_s1_r <= link.mode_select_pins;
         mode_s2_r <= mode_s1_r;
         clk_d_r   <= clk_s_r[1];
         wr_d_r    <= wr_s_r[1];
      end
   end

   // Mode is caught once the synchroniser holds pin values, not its reset value.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         mode_r      <= cfgld_pkg::CFGLD_M_SSER;
         mode_ok_r   <= 1'b0;
         mode_wait_r <= 2'h0;
      end else if (!mode_ok_r) begin
         if (mode_wait_r == 2'h2) begin
            mode_r    <= cfgld_pkg::cfgld_mode_e'(mode_s2_r);
            mode_ok_r <= 1'b1;
         end else begin
            mode_wait_r <= mode_wait_r + 2'h1;
         end
      end
   end

   assign ext_clk   = mode_r == cfgld_pkg::CFGLD_M_SSER || mode_r == cfgld_pkg::CFGLD_M_PSYN;
   assign byte_mode = mode_r == cfgld_pkg::CFGLD_M_PSYN || mode_r == cfgld_pkg::CFGLD_M_PASY;

   // Clock generator for master serial and asynchronous peripheral modes.
   assign run  = mode_ok_r && !o_finished && st_r != CFGLD_S_ERR &&
                 (mode_r == cfgld_pkg::CFGLD_M_MSER ||
                  (mode_r == cfgld_pkg::CFGLD_M_PASY && (bits_r != 4'h0 || match_r)));
   assign tick = run && div_r == 4'h0;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         div_r     <= 4'h0;
         gen_clk_r <= 1'b1;
      end else if (run) begin
         if (div_r == 4'h0) begin
            div_r     <= fast_r ? 4'(cfgld_pkg::FAST_HALF - 1)
                                : 4'(cfgld_pkg::SLOW_HALF - 1);
            gen_clk_r <= !gen_clk_r;
         end else begin
            div_r <= div_r - 4'h1;
         end
      end else begin
         div_r <= 4'h0;
      end
   end

   assign link.dev_clk_o  = gen_clk_r;
   assign link.dev_clk_oe = mode_ok_r && !ext_clk;
   assign rise = ext_clk ? (clk_s_r[1] && !clk_d_r) : (tick && !gen_clk_r);
   assign fall = ext_clk ? (!clk_s_r[1] && clk_d_r) : (tick && gen_clk_r);

   // Byte path: bytes enter the FIFO, ready/busy shows its room.
   assign wr_fall       = byte_mode && !wr_s_r[1] && wr_d_r;
   assign link.rdy_busy = f_ready;
   assign f_pop         = f_valid && bits_r == 4'h0;

   cfgld_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_data     (dat_s2_r),
      .i_valid    (wr_fall),
      .o_ready    (f_ready),
      .o_data     (f_data),
      .o_valid    (f_valid),
      .i_ready    (f_pop)
   );

   // Serialiser shifts D0 out first on each rising clock.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         sr_r   <= 8'hFF;
         bits_r <= 4'h0;
      end else if (f_pop) begin
         sr_r   <= f_data;
         bits_r <= 4'h8;
      end else if (rise && bits_r != 4'h0) begin
         sr_r   <= {1'b1, sr_r[7:1]};
         bits_r <= bits_r - 4'h1;
      end
   end

   assign bit_in = byte_mode ? (bits_r == 4'h0 || sr_r[0]) : din_s_r[1];

   // Bitstream parser.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         st_r     <= CFGLD_S_HDR;
         sh_r     <= cfgld_pkg::FILL_BYTE;
         bcnt_r   <= 16'h0;
         fcnt_r   <= 16'h0;
         len_r    <= '0;
         len_ok_r <= 1'b0;
         fast_r   <= 1'b0;
      end else if (rise && mode_ok_r) begin
         sh_r <= {sh_r[6:0], bit_in};
         unique case (st_r)
            CFGLD_S_HDR: begin
               if ({sh_r[2:0], bit_in} == cfgld_pkg::PREAMBLE) begin
                  st_r   <= CFGLD_S_LEN;
                  bcnt_r <= 16'h0;
               end
            end
            CFGLD_S_LEN: begin
               len_r  <= {len_r[cfgld_pkg::LEN_W-2:0], bit_in};
               bcnt_r <= bcnt_r + 16'h1;
               if (bcnt_r == 16'(cfgld_pkg::LEN_BITS - 5'h1)) begin
                  st_r     <= CFGLD_S_FILL;
                  len_ok_r <= 1'b1;
                  bcnt_r   <= 16'h0;
               end
            end
            CFGLD_S_FILL: begin
               bcnt_r <= bcnt_r + 16'h1;
               if (bcnt_r == 16'(cfgld_pkg::FILL_N - 3'h1)) begin
                  st_r <= ({sh_r[2:0], bit_in} == cfgld_pkg::FILL_BITS) ?
                          CFGLD_S_START : CFGLD_S_ERR;
               end
            end
            CFGLD_S_START: begin
               if (!bit_in) begin
                  st_r   <= CFGLD_S_DATA;
                  bcnt_r <= 16'h0;
               end
            end
            CFGLD_S_DATA: begin
               if (fcnt_r == 16'h0 && bcnt_r == 16'h0) begin
                  fast_r <= bit_in;
               end
               bcnt_r <= bcnt_r + 16'h1;
               if (bcnt_r == 16'(FRAME_BITS - 1)) begin
                  st_r   <= CFGLD_S_CHK;
                  bcnt_r <= 16'h0;
               end
            end
            CFGLD_S_CHK: begin
               bcnt_r <= bcnt_r + 16'h1;
               if (bcnt_r == 16'(cfgld_pkg::CHK_N - 3'h1)) begin
                  bcnt_r <= 16'h0;
                  fcnt_r <= fcnt_r + 16'h1;
                  if ({sh_r[2:0], bit_in} != cfgld_pkg::CHECK_CONST) begin
                     st_r <= CFGLD_S_ERR;
                  end else if (fcnt_r == 16'(FRAMES - 1)) begin
                     st_r <= CFGLD_S_POST;
                  end else begin
                     st_r <= CFGLD_S_START;
                  end
               end
            end
            CFGLD_S_POST: begin
               bcnt_r <= bcnt_r + 16'h1;
               if (bcnt_r == 16'(cfgld_pkg::POST_N - 4'h1)) begin
                  st_r <= ({sh_r[6:0], bit_in} == cfgld_pkg::POSTAMBLE) ?
                          CFGLD_S_PASS : CFGLD_S_ERR;
               end
            end
            CFGLD_S_PASS: begin
               st_r <= CFGLD_S_PASS;
            end
            CFGLD_S_ERR: begin
               st_r <= CFGLD_S_ERR;
            end
            default: begin
               st_r <= CFGLD_S_ERR;
            end
         endcase
      end
   end

   // Daisy-chain output: sample on rise, drive on the following fall.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         samp_r <= 1'b1;
         pass_r <= 1'b1;
         dout_r <= 1'b1;
      end else begin
         if (rise) begin
            samp_r <= bit_in;
            pass_r <= st_r == CFGLD_S_HDR || st_r == CFGLD_S_LEN ||
                      st_r == CFGLD_S_PASS;
         end
         if (fall) begin
            dout_r <= pass_r ? samp_r : 1'b1;
         end
      end
   end
   assign link.dout = dout_r;

   // Length-count match and start-up sequencing.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         ccnt_r       <= '0;
         match_r      <= 1'b0;
         post_r       <= 3'h0;
         o_done       <= 1'b0;
         o_io_release <= 1'b0;
         o_finished   <= 1'b0;
      end else if (rise && mode_ok_r && st_r != CFGLD_S_ERR) begin
         ccnt_r <= ccnt_r + 1'b1;
         if (!match_r && len_ok_r && ccnt_r + 1'b1 == len_r) begin
            match_r <= 1'b1;
            o_done  <= 1'b1;
         end
         if (match_r && !o_finished) begin
            post_r <= post_r + 3'h1;
            if (post_r + 3'h1 == cfgld_pkg::IO_REL_CLKS) begin
               o_io_release <= 1'b1;
            end
            if (post_r + 3'h1 == cfgld_pkg::STARTUP_CLKS) begin
               o_finished <= 1'b1;
            end
         end
      end
   end

   assign link.init_n_o  = 1'b0;
   assign link.init_n_oe = st_r == CFGLD_S_ERR;
   assign o_error        = st_r == CFGLD_S_ERR;
   assign o_fast_clk     = fast_r;
endmodule // cfgld_device

// ---- rtl/cfgld_host.sv ----
// Configuration source end: serial shifter, clock maker and byte writer.
module cfgld_host (
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   cfgld_if.host           link,
   input  wire logic [2:0] i_mode,
   input  wire logic [7:0] i_byte,
   input  wire logic       i_byte_valid,
   output logic            o_byte_ready,
   output logic            o_init_error
);
   logic [1:0] clk_s_r;
   logic       clk_d_r;
   logic [1:0] rdy_s_r;
   logic [1:0] init_s_r;
   logic       hclk_r;
   logic [3:0] div_r;
   logic       make_clk;
   logic       serial;
   logic       fall;
   logic [7:0] sr_r;
   logic [3:0] bits_r;
   logic       din_r;
   logic [7:0] data_r;
   logic       wr_n_r;
   logic [2:0] wcnt_r;
   logic [2:0] rec_r;
   logic       take;

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         clk_s_r  <= 2'h3;
         clk_d_r  <= 1'b1;
         rdy_s_r  <= 2'h0;
         init_s_r <= 2'h3;
      end else begin
         clk_s_r  <= {clk_s_r[0], link.config_clock};
         clk_d_r  <= clk_s_r[1];
         rdy_s_r  <= {rdy_s_r[0], link.rdy_busy};
         init_s_r <= {init_s_r[0], link.init_n};
      end
   end

   assign link.mode_select_pins = i_mode;
   assign make_clk = i_mode == cfgld_pkg::CFGLD_M_SSER || i_mode == cfgld_pkg::CFGLD_M_PSYN;
   assign serial   = i_mode == cfgld_pkg::CFGLD_M_SSER || i_mode == cfgld_pkg::CFGLD_M_MSER;
   assign o_init_error = !init_s_r[1];

   // Free-running link clock so start-up can reach its finish point.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         div_r  <= 4'h0;
         hclk_r <= 1'b1;
      end else if (make_clk) begin
         if (div_r == 4'h0) begin
            div_r  <= 4'(cfgld_pkg::HOST_HALF - 1);
            hclk_r <= !hclk_r;
         end else begin
            div_r <= div_r - 4'h1;
         end
      end
   end
   assign link.host_clk_o  = hclk_r;
   assign link.host_clk_oe = make_clk;
   assign fall = make_clk ? (div_r == 4'h0 && hclk_r) : (!clk_s_r[1] && clk_d_r);

   assign take = i_byte_valid && o_byte_ready;
   assign o_byte_ready = serial ? bits_r == 4'h0
                                : (wcnt_r == 3'h0 && rec_r == 3'h0 && rdy_s_r[1]);

   // Serial shifter: next bit presented on each falling clock, D0 first.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         sr_r   <= 8'hFF;
         bits_r <= 4'h0;
         din_r  <= 1'b1;
      end else begin
         if (take && serial) begin
            sr_r   <= i_byte;
            bits_r <= 4'h8;
         end else if (fall && serial) begin
            din_r <= bits_r == 4'h0 || sr_r[0];
            if (bits_r != 4'h0) begin
               sr_r   <= {1'b1, sr_r[7:1]};
               bits_r <= bits_r - 4'h1;
            end
         end
      end
   end
   assign link.din = din_r;

   // Peripheral write strobe followed by a recovery gap for ready/busy.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         data_r <= 8'hFF;
         wr_n_r <= 1'b1;
         wcnt_r <= 3'h0;
         rec_r  <= 3'h0;
      end else if (take && !serial) begin
         data_r <= i_byte;
         wr_n_r <= 1'b0;
         wcnt_r <= cfgld_pkg::WR_CYCLES;
      end else if (wcnt_r != 3'h0) begin
         wcnt_r <= wcnt_r - 3'h1;
         if (wcnt_r == 3'h1) begin
            wr_n_r <= 1'b1;
            rec_r  <= cfgld_pkg::WR_RECOVER;
         end
      end else if (rec_r != 3'h0) begin
         rec_r <= rec_r - 3'h1;
      end
   end
   assign link.data = data_r;
   assign link.wr_n = wr_n_r;
endmodule // cfgld_host

// ---- sim/cfgld_monitor.sv ----
// Concurrent checks on the link between the two loader ends.
module cfgld_monitor #(
   parameter int LEN = 152
) (
   input wire logic       i_core_clk,
   input wire logic       i_rst,
   input wire logic       config_clock,
   input wire logic       din,
   input wire logic       dout,
   input wire logic [2:0] mode_select_pins,
   input wire logic       wr_n,
   input wire logic       rdy_busy,
   input wire logic       init_n,
   input wire logic       dev_clk_oe,
   input wire logic       o_done,
   input wire logic       o_io_release,
   input wire logic       o_finished,
   input wire logic       o_error,
   input wire logic       o_fast_clk
);
   logic cc_r;
   logic rise;
   int   rise_cnt_r;
   int   done_cnt_r;
   assign rise = config_clock & ~cc_r;
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);
   // Counts link clock rises since reset and since the length match.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         cc_r       <= 1'h1;
         rise_cnt_r <= 0;
         done_cnt_r <= 0;
      end else begin
         cc_r       <= config_clock;
         rise_cnt_r <= rise_cnt_r + int'(rise);
         done_cnt_r <= done_cnt_r + int'(rise & o_done);
      end
   end
   sequence s_strobe; !wr_n [*4]; endsequence
   sequence s_recover; wr_n [*6]; endsequence
   property p_wr_strobe; $fell(wr_n) |-> s_strobe ##1 s_recover; endproperty
   a_wr_strobe: assert property (p_wr_strobe)
      else $error("write strobe shape wrong");
   property p_no_wr_busy; $fell(wr_n) |-> rdy_busy && $past(rdy_busy, 2); endproperty
   a_no_wr_busy: assert property (p_no_wr_busy)
      else $error("byte written while busy");
   property p_done_len;
      $rose(o_done) && !o_fast_clk |-> rise_cnt_r + int'(rise) == LEN;
   endproperty
   a_done_len: assert property (p_done_len)
      else $error("done not at length count");
   property p_io_rel; $rose(o_io_release) && !o_fast_clk |-> done_cnt_r == 2; endproperty
   a_io_rel: assert property (p_io_rel)
      else $error("io release off by clocks");
   property p_fin; $rose(o_finished) && !o_fast_clk |-> done_cnt_r == 4; endproperty
   a_fin: assert property (p_fin)
      else $error("finish point off by clocks");
   property p_err_init; $rose(o_error) |-> ##[0:4] !init_n; endproperty
   a_err_init: assert property (p_err_init)
      else $error("init not pulled low on error");
   property p_din_hold; $rose(config_clock) |-> $stable(din) [*3]; endproperty
   a_din_hold: assert property (p_din_hold)
      else $error("serial input moved at sampling");
   property p_dout_fall;
      $changed(dout) && mode_select_pins == cfgld_pkg::CFGLD_M_SSER |-> !$past(config_clock, 3);
   endproperty
   a_dout_fall: assert property (p_dout_fall)
      else $error("serial output not retimed to falling edge");
   property p_clk_owner; mode_select_pins[1:0] == 2'h3 |-> !dev_clk_oe; endproperty
   a_clk_owner: assert property (p_clk_owner)
      else $error("device drives clock in an input clock mode");
endmodule // cfgld_monitor

// ---- sim/cfgld_test.sv ----
// Bench driving the source end and watching the loading end across one link.
module cfgld_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LEN = 152;
   logic       i_core_clk;
   logic       i_rst;
   logic [2:0] mode;
   logic [7:0] byte_d;
   logic       byte_v;
   logic       byte_rdy;
   logic       init_err;
   logic       done;
   logic       io_rel;
   logic       fin;
   logic       err;
   logic       fast;
   logic       cc_r;
   logic       busy_seen;
   logic       dq[$];
   int         n_fail;
   int         checks;
   int         cycles;
   cfgld_if cfgld_if_i ();
   cfgld_host cfgld_host_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .link(cfgld_if_i),
      .i_mode(mode), .i_byte(byte_d), .i_byte_valid(byte_v), .o_byte_ready(byte_rdy),
      .o_init_error(init_err));
   cfgld_device #(.FRAME_BITS(16), .FRAMES(4), .FIFO_DEPTH(16)) cfgld_device_i (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .link(cfgld_if_i), .o_done(done),
      .o_io_release(io_rel), .o_finished(fin), .o_error(err), .o_fast_clk(fast));
   cfgld_monitor #(.LEN(LEN)) cfgld_monitor_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
      .config_clock(cfgld_if_i.config_clock), .din(cfgld_if_i.din), .dout(cfgld_if_i.dout),
      .mode_select_pins(cfgld_if_i.mode_select_pins), .wr_n(cfgld_if_i.wr_n),
      .rdy_busy(cfgld_if_i.rdy_busy), .init_n(cfgld_if_i.init_n),
      .dev_clk_oe(cfgld_if_i.dev_clk_oe), .o_done(done), .o_io_release(io_rel),
      .o_finished(fin), .o_error(err), .o_fast_clk(fast));
   initial begin
      i_core_clk = 1'h0;
      forever #25 i_core_clk = ~i_core_clk;
   end
   task automatic close_out();
      if (n_fail == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic got, input logic want, input string what);
      checks++;
      if (got !== want) begin
         n_fail++;
         $display("MISMATCH %0t %s", $time, what);
      end
   endtask
   // Records the serial output at each link clock rise and watches the buffer.
   always @(negedge i_core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         close_out();
      end
      if (cfgld_if_i.config_clock && !cc_r) dq.push_back(cfgld_if_i.dout);
      if (!cfgld_if_i.rdy_busy) busy_seen = 1'h1;
      cc_r = cfgld_if_i.config_clock;
   end
   // Loads one full bitstream in mode m and checks the outcome.
   task automatic run(input logic [2:0] m, input logic [3:0] chk, input logic f);
      logic [159:0] sv;
      logic [83:0]  fr;
      logic [15:0]  d;
      int           off;
      fr = '0;
      for (int i = 0; i < 4; i++) begin
         d = 16'($urandom);
         if (i == 0) d[15] = f;
         fr = {fr[62:0], 1'h0, d, chk};
      end
      sv = {cfgld_pkg::FILL_BYTE, cfgld_pkg::PREAMBLE, 24'(LEN), cfgld_pkg::FILL_BITS, fr,
            cfgld_pkg::POSTAMBLE, 28'($urandom)};
      @(negedge i_core_clk);
      i_rst = 1'h1;
      mode = m;
      dq.delete();
      busy_seen = 1'h0;
      repeat (2) @(negedge i_core_clk);
      i_rst = 1'h0;
      repeat (4) @(negedge i_core_clk);
      for (int i = 0; i < 20; i++) begin
         for (int j = 0; j < 8; j++) byte_d[j] = sv[159 - 8 * i - j];
         byte_v = 1'h1;
         while (!byte_rdy) @(negedge i_core_clk);
         @(negedge i_core_clk);
      end
      byte_v = 1'h0;
      for (int i = 0; i < 4000 && !fin && !err; i++) @(negedge i_core_clk);
      repeat (4) @(negedge i_core_clk);
      if (chk !== cfgld_pkg::CHECK_CONST) begin
         cmp(err, 1'h1, "frame error missed");
         cmp(init_err, 1'h1, "init not seen low");
         cmp(done, 1'h0, "done after bad frame");
      end else begin
         cmp(done, 1'h1, "length match missed");
         cmp(io_rel, 1'h1, "io not released");
         cmp(fin, 1'h1, "finish not reached");
         cmp(fast, f, "clock rate option wrong");
         if (m == cfgld_pkg::CFGLD_M_PSYN) cmp(busy_seen, 1'h1, "buffer never full");
         off = -1;
         foreach (dq[k]) if (off < 0 && dq[k] === 1'h0) off = k - 9;
         cmp(off >= 0 && off <= 4, 1'h1, "header not passed on");
         for (int s = 0; s < (f ? 40 : LEN - 14); s++) begin
            if (s + off + 1 < dq.size())
               cmp(dq[s + off + 1], (s < 40 || s >= 132) ? sv[159 - s] : 1'h1, "chain out");
         end
      end
   endtask
   initial begin
      i_rst = 1'h1;
      mode = 3'h7;
      byte_d = 8'hFF;
      byte_v = 1'h0;
      cc_r = 1'h1;
      void'($urandom(32'hE8CC));
      run(cfgld_pkg::CFGLD_M_SSER, cfgld_pkg::CHECK_CONST, 1'h0);
      run(cfgld_pkg::CFGLD_M_PSYN, cfgld_pkg::CHECK_CONST, 1'h0);
      run(cfgld_pkg::CFGLD_M_PASY, cfgld_pkg::CHECK_CONST, 1'h1);
      run(cfgld_pkg::CFGLD_M_MSER, cfgld_pkg::CHECK_CONST, 1'h0);
      run(cfgld_pkg::CFGLD_M_SSER, cfgld_pkg::CHECK_CONST ^ 4'($urandom_range(15, 1)), 1'h0);
      close_out();
   end
endmodule // cfgld_test
